// ---- hw/rx_qual_consts.svh ----
// Purpose: constants for the receive qualifier and modulation control block
// Assumes: 20 MHz i_clk, byte-wide register port
// Notes:   offsets are register indices on the plain register port
`ifndef RX_QUAL_CONSTS_SVH
`define RX_QUAL_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_SYNC_HIGH     4'h0
`define OFS_SYNC_LOW      4'h1
`define OFS_PKT_CTRL1     4'h2
`define OFS_MODEM_CFG2    4'h3
`define OFS_DEVIATION     4'h4
`define OFS_GAIN_CTRL0    4'h5
`define OFS_CS_CTRL       4'h6
`define OFS_PIN_CFG       4'h7
`define OFS_STATE_FLAGS   4'h8
`define OFS_RSSI          4'h9
`define OFS_STATUS_BYTE   4'hA
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define RST_SYNC_HIGH     8'hD3
`define RST_SYNC_LOW      8'h91
`define RST_PKT_CTRL1     8'h04
`define RST_MODEM_CFG2    8'h02
`define RST_DEVIATION     8'h47
`define RST_GAIN_CTRL0    8'h00
`define RST_CS_CTRL       8'h00
`define RST_PIN_CFG       8'h00
`define PQ_DEC_STEP       8'h08
`define PQ_INC_STEP       8'h01
`define PQ_MULT_SHIFT     2
`define PIN_SEL_PQ_MET    4'h8
`define PIN_SEL_CS        4'hE
`define DEV_MANT_BASE     4'h8
`define DEV_SCALE_SHIFT   17
`define RSSI_DECIM_BASE   3
`define CS_HYST           8'h02
`endif

// ---- hw/rx_qual_pkg.sv ----
// Purpose: types for the receive qualifier block
// Assumes: nothing
// Notes:   encodings follow the modulation and sync select fields
package rx_qual_pkg;
    typedef enum logic [2:0] {
        MOD_FSK2 = 3'h0,
        MOD_GFSK = 3'h1,
        MOD_RSV2 = 3'h2,
        MOD_RSV3 = 3'h3,
        MOD_RSV4 = 3'h4,
        MOD_RSV5 = 3'h5,
        MOD_RSV6 = 3'h6,
        MOD_MSK  = 3'h7
    } mod_format_t;
    typedef enum logic [1:0] {
        SYNC_NONE  = 2'h0,
        SYNC_15_16 = 2'h1,
        SYNC_16_16 = 2'h2,
        SYNC_30_32 = 2'h3
    } sync_match_t;
endpackage

// ---- hw/pq_counter.sv ----
// Purpose: preamble quality estimator
// Assumes: i_bit_en pulses once per received bit
// Notes:   saturates at both ends so noise cannot wrap it
`include "rx_qual_consts.svh"
module pq_counter #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_clear,
    input  wire logic         i_bit_en,
    input  wire logic         i_bit,
    output logic [W-1:0]      o_count
);
    logic prev_reg;
    logic have_prev_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count       <= '0;
            prev_reg      <= 1'b0;
            have_prev_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_clear) begin
                o_count       <= '0;
                have_prev_reg <= 1'b0;
            end else if (i_bit_en) begin
                prev_reg      <= i_bit;
                have_prev_reg <= 1'b1;
                if (have_prev_reg && (i_bit != prev_reg)) begin
                    if (o_count != {W{1'b1}})
                        o_count <= o_count + W'(`PQ_INC_STEP);
                end else if (have_prev_reg) begin
                    if (o_count > W'(`PQ_DEC_STEP))
                        o_count <= o_count - W'(`PQ_DEC_STEP);
                    else
                        o_count <= '0;
                end
            end
        end
    end
endmodule

// ---- hw/rx_sync_qualifier_rssi.sv ----
// Purpose: modulation control, sync qualifier, preamble quality, rssi and carrier sense
// Assumes: front end gives bits, rssi samples and tx symbols on i_clk; pins pre-synced
// Notes:   analog shaping is outside; this block drives control words to the modem
//
// Notes on behaviour
// - fsk zero sends negative deviation, one sends positive deviation
// - deviation equals fref over 2^17 times (8+mantissa) times 2^exponent
// - gfsk selects gaussian shaping with bandwidth-time product one
// - msk covers preamble, sync word and payload alike
// - msk phase change time fixed; mantissa sets fraction of symbol
// - msk modulator inverts sync word and data bits
// - msk ignores deviation in receive; software keeps manchester off
// - no rx data writes or filtering before valid sync when enabled
// - select 0 none, 1 fifteen of sixteen, 2 sixteen, 3 thirty of 32
// - selects 4 to 7 repeat 0 to 3 plus carrier sense
// - sync accepted only after preamble quality above threshold
// - quality counter plus one on bit change, minus eight on repeat
// - gate at four times threshold field; zero disables qualifier
// - quality met shown in status bit and on pin select 1000
// - rssi tracks until sync found, then frozen until rx reentered
// - rssi is two's complement in half decibel steps
// - rssi updates every 8 times 2^averaging length filter samples
// - rssi at sync goes into first appended status byte
// - absolute carrier sense with hysteresis around threshold
// - relative carrier sense on rise or fall by set step
// - sync search only while carrier sense is up, if qualified
// - carrier sense in status bit and on pin select 1110
// - two-byte sync word, sent and searched twice in 30 of 32
//
// The register offsets and the strobed register port were decided locally.
`include "rx_qual_consts.svh"
module rx_sync_qualifier_rssi #(
    parameter int PQ_W   = 8,
    parameter int FREF_HZ = 26000000
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    input  wire logic        i_rx_active,
    input  wire logic        i_rx_bit_en,
    input  wire logic        i_rx_bit,
    input  wire logic        i_rx_byte_en,
    input  wire logic [7:0]  i_rx_byte,
    input  wire logic        i_rssi_sample_en,
    input  wire logic [7:0]  i_rssi_sample,
    input  wire logic        i_tx_sym_en,
    input  wire logic        i_tx_sym,
    input  wire logic        i_tx_sync_phase,
    output logic             o_rx_data_en,
    output logic [7:0]       o_rx_data,
    output logic             o_sync_found,
    output logic             o_tx_dev_pos,
    output logic [31:0]      o_dev_hz,
    output logic             o_gauss_en,
    output logic             o_msk_en,
    output logic [2:0]       o_msk_phase_frac,
    output logic             o_rx_dev_use,
    output logic             o_tx_sync_repeat,
    output logic             o_pin_out
);
    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0] sync_pattern_high_reg;
    logic [7:0] sync_pattern_low_reg;
    logic [7:0] packet_control_1_reg;
    logic [7:0] modem_config_2_reg;
    logic [7:0] freq_deviation_config_reg;
    logic [7:0] gain_control_0_reg;
    logic [7:0] cs_control_reg;
    logic [7:0] pin_output_config_reg;
    logic [7:0] rssi_reg;
    logic [7:0] rssi_at_sync_reg;
    logic       cs_reg;
    logic       pq_met_reg;
    logic       sync_seen_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_pattern_high_reg     <= `RST_SYNC_HIGH;
            sync_pattern_low_reg      <= `RST_SYNC_LOW;
            packet_control_1_reg      <= `RST_PKT_CTRL1;
            modem_config_2_reg        <= `RST_MODEM_CFG2;
            freq_deviation_config_reg <= `RST_DEVIATION;
            gain_control_0_reg        <= `RST_GAIN_CTRL0;
            cs_control_reg            <= `RST_CS_CTRL;
            pin_output_config_reg     <= `RST_PIN_CFG;
        end else if (i_ce && i_wr) begin
            unique case (i_addr)
                `OFS_SYNC_HIGH:   sync_pattern_high_reg     <= i_wdata;
                `OFS_SYNC_LOW:    sync_pattern_low_reg      <= i_wdata;
                `OFS_PKT_CTRL1:   packet_control_1_reg      <= i_wdata;
                `OFS_MODEM_CFG2:  modem_config_2_reg        <= i_wdata;
                `OFS_DEVIATION:   freq_deviation_config_reg <= i_wdata;
                `OFS_GAIN_CTRL0:  gain_control_0_reg        <= i_wdata;
                `OFS_CS_CTRL:     cs_control_reg            <= i_wdata;
                `OFS_PIN_CFG:     pin_output_config_reg     <= i_wdata;
                default: ;
            endcase
        end
    end

    // field views
    logic [2:0] pqt_field;
    logic       trailer_en;
    logic [2:0] sync_mode;
    logic       cs_qualify;
    logic [2:0] mod_fmt;
    logic [2:0] dev_mant;
    logic [2:0] dev_exp;
    logic [1:0] avg_len;
    logic [6:0] cs_abs_thr;
    logic       cs_abs_en;
    logic [1:0] cs_rel_sel;
    logic [3:0] pin_sel;
    assign pqt_field  = packet_control_1_reg[7:5];
    assign trailer_en = packet_control_1_reg[2];
    assign sync_mode  = modem_config_2_reg[2:0];
    assign cs_qualify = sync_mode[2];
    assign mod_fmt    = modem_config_2_reg[6:4];
    assign dev_mant   = freq_deviation_config_reg[2:0];
    assign dev_exp    = freq_deviation_config_reg[6:4];
    assign avg_len    = gain_control_0_reg[1:0];
    assign cs_abs_thr = cs_control_reg[6:0];
    assign cs_abs_en  = cs_control_reg[7];
    assign cs_rel_sel = pin_output_config_reg[5:4];
    assign pin_sel    = pin_output_config_reg[3:0];

    // read port, data one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_rd) begin
                unique case (i_addr)
                    `OFS_SYNC_HIGH:   o_rdata <= sync_pattern_high_reg;
                    `OFS_SYNC_LOW:    o_rdata <= sync_pattern_low_reg;
                    `OFS_PKT_CTRL1:   o_rdata <= packet_control_1_reg;
                    `OFS_MODEM_CFG2:  o_rdata <= modem_config_2_reg;
                    `OFS_DEVIATION:   o_rdata <= freq_deviation_config_reg;
                    `OFS_GAIN_CTRL0:  o_rdata <= gain_control_0_reg;
                    `OFS_CS_CTRL:     o_rdata <= cs_control_reg;
                    `OFS_PIN_CFG:     o_rdata <= pin_output_config_reg;
                    `OFS_STATE_FLAGS: o_rdata <= {1'b0, cs_reg, pq_met_reg, 4'h0,
                                                  sync_seen_reg};
                    `OFS_RSSI:        o_rdata <= rssi_reg;
                    `OFS_STATUS_BYTE: o_rdata <= trailer_en ? rssi_at_sync_reg : 8'h00;
                    default:          o_rdata <= 8'h00;
                endcase
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // transmit modulation control
    // ----------------------------------------
    function automatic logic [31:0] dev_hz(input logic [2:0] m, input logic [2:0] e);
        logic [63:0] p;
        p = 64'(FREF_HZ) * 64'({1'b0, m} + `DEV_MANT_BASE);
        p = (p << e) >> `DEV_SCALE_SHIFT;
        return p[31:0];
    endfunction

    logic is_msk;
    assign is_msk = (mod_fmt == rx_qual_pkg::MOD_MSK);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_dev_pos     <= 1'b0;
            o_dev_hz         <= 32'h0;
            o_gauss_en       <= 1'b0;
            o_msk_en         <= 1'b0;
            o_msk_phase_frac <= 3'h0;
            o_rx_dev_use     <= 1'b0;
            o_tx_sync_repeat <= 1'b0;
        end else if (i_ce) begin
            o_dev_hz         <= dev_hz(dev_mant, dev_exp);
            o_gauss_en       <= (mod_fmt == rx_qual_pkg::MOD_GFSK);
            o_msk_en         <= is_msk;
            o_msk_phase_frac <= is_msk ? dev_mant : 3'h0;
            o_rx_dev_use     <= !is_msk;
            o_tx_sync_repeat <= (sync_mode[1:0] == rx_qual_pkg::SYNC_30_32);
            if (i_tx_sym_en)
                // msk inverts every bit, preamble and sync phases included
                o_tx_dev_pos <= is_msk ? ~i_tx_sym : i_tx_sym;
        end
    end

    // ----------------------------------------
    // rssi averaging, freeze and carrier sense
    // ----------------------------------------
    logic [5:0] rssi_div_reg;
    logic [5:0] rssi_div_top;
    logic       rssi_tick;
    logic       rx_prev_reg;
    logic       rx_enter;
    assign rssi_div_top = 6'((6'h1 << (`RSSI_DECIM_BASE + avg_len)) - 6'h1);
    assign rssi_tick    = i_rssi_sample_en && (rssi_div_reg >= rssi_div_top);
    assign rx_enter     = i_rx_active && !rx_prev_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rssi_div_reg <= 6'h0;
            rx_prev_reg  <= 1'b0;
        end else if (i_ce) begin
            rx_prev_reg <= i_rx_active;
            if (rx_enter || rssi_tick)
                rssi_div_reg <= 6'h0;
            else if (i_rssi_sample_en)
                rssi_div_reg <= rssi_div_reg + 6'h1;
        end
    end

    logic [7:0] rssi_prev_reg;
    logic [7:0] rel_step;
    logic       cs_abs;
    logic       cs_rel_reg;
    logic signed [8:0] rssi_diff;
    logic signed [7:0] abs_thr_half;
    assign rel_step     = (cs_rel_sel == 2'h1) ? 8'h0C : (cs_rel_sel == 2'h2) ? 8'h14 : 8'h1C;
    assign rssi_diff    = 9'($signed(i_rssi_sample)) - 9'($signed(rssi_prev_reg));
    assign abs_thr_half = -$signed({1'b0, cs_abs_thr});

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rssi_reg      <= 8'h80;
            rssi_prev_reg <= 8'h80;
            cs_rel_reg    <= 1'b0;
            cs_abs        <= 1'b0;
        end else if (i_ce) begin
            if (!i_rx_active) begin
                cs_rel_reg <= 1'b0;
                cs_abs     <= 1'b0;
            end else if (rssi_tick) begin
                if (!sync_seen_reg || sync_mode[1:0] == rx_qual_pkg::SYNC_NONE)
                    rssi_reg <= i_rssi_sample;
                rssi_prev_reg <= i_rssi_sample;
                if (cs_rel_sel != 2'h0) begin
                    if (rssi_diff >= $signed({1'b0, rel_step}))
                        cs_rel_reg <= 1'b1;
                    else if (rssi_diff <= -$signed({1'b0, rel_step}))
                        cs_rel_reg <= 1'b0;
                end
                if ($signed(i_rssi_sample) > abs_thr_half + $signed(`CS_HYST))
                    cs_abs <= cs_abs_en;
                else if ($signed(i_rssi_sample) < abs_thr_half - $signed(`CS_HYST))
                    cs_abs <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            cs_reg <= 1'b0;
        else if (i_ce)
            cs_reg <= cs_abs || cs_rel_reg;
    end

    // ----------------------------------------
    // preamble quality and sync search
    // ----------------------------------------
    logic [PQ_W-1:0] pq_count;
    logic [PQ_W-1:0] pq_gate;
    pq_counter #(.W(PQ_W)) u_pq (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .i_clear  (rx_enter || !i_rx_active),
        .i_bit_en (i_rx_bit_en),
        .i_bit    (i_rx_bit),
        .o_count  (pq_count)
    );
    assign pq_gate = PQ_W'({pqt_field, 2'b00});

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            pq_met_reg <= 1'b0;
        else if (i_ce)
            pq_met_reg <= (pqt_field != 3'h0) && (pq_count > pq_gate);
    end

    logic [31:0] shift_reg;
    logic [15:0] sync_word;
    logic [4:0]  m16;
    logic [5:0]  m32;
    logic        bits_ok;
    logic        qual_ok;
    assign sync_word = {sync_pattern_high_reg, sync_pattern_low_reg};

    function automatic logic [5:0] ones32(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h0;
        for (int k = 0; k < 32; k++)
            n = n + 6'(v[k]);
        return n;
    endfunction

    assign m16 = 5'(ones32({16'h0, ~(shift_reg[15:0] ^ sync_word)}));
    assign m32 = ones32(~(shift_reg ^ {sync_word, sync_word}));
    always_comb begin
        unique case (rx_qual_pkg::sync_match_t'(sync_mode[1:0]))
            rx_qual_pkg::SYNC_NONE:  bits_ok = 1'b1;
            rx_qual_pkg::SYNC_15_16: bits_ok = (m16 >= 5'd15);
            rx_qual_pkg::SYNC_16_16: bits_ok = (m16 == 5'd16);
            rx_qual_pkg::SYNC_30_32: bits_ok = (m32 >= 6'd30);
        endcase
    end
    assign qual_ok = (!cs_qualify || cs_reg)
                  && ((pqt_field == 3'h0) || pq_met_reg);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg        <= 32'h0;
            sync_seen_reg    <= 1'b0;
            o_sync_found     <= 1'b0;
            rssi_at_sync_reg <= 8'h80;
        end else if (i_ce) begin
            o_sync_found <= 1'b0;
            if (!i_rx_active || rx_enter) begin
                sync_seen_reg <= 1'b0;
                shift_reg     <= 32'h0;
            end else if (sync_mode[1:0] == rx_qual_pkg::SYNC_NONE) begin
                sync_seen_reg <= !cs_qualify || cs_reg;
            end else if (i_rx_bit_en && !sync_seen_reg) begin
                shift_reg <= {shift_reg[30:0], i_rx_bit};
            end else if (!sync_seen_reg && bits_ok && qual_ok && !i_rx_bit_en) begin
                sync_seen_reg    <= 1'b1;
                o_sync_found     <= 1'b1;
                rssi_at_sync_reg <= rssi_reg;
            end
        end
    end

    // ----------------------------------------
    // receive data gate and pin mux
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_data_en <= 1'b0;
            o_rx_data    <= 8'h00;
            o_pin_out    <= 1'b0;
        end else if (i_ce) begin
            // bytes before sync would let filtering act on noise
            o_rx_data_en <= i_rx_byte_en && sync_seen_reg;
            if (i_rx_byte_en && sync_seen_reg)
                o_rx_data <= i_rx_byte;
            o_pin_out <= (pin_sel == `PIN_SEL_PQ_MET) ? pq_met_reg :
                         (pin_sel == `PIN_SEL_CS)     ? cs_reg : 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_no_data_before_sync;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rx_byte_en && !sync_seen_reg) |=> !o_rx_data_en;
    endproperty
    a_no_data_before_sync: assert property (p_no_data_before_sync)
        else $error("rx data passed before sync");

    property p_pin_cs;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && pin_sel == `PIN_SEL_CS) |=> (o_pin_out == $past(cs_reg));
    endproperty
    a_pin_cs: assert property (p_pin_cs)
        else $error("pin does not show carrier sense");

    property p_pin_pq;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && pin_sel == `PIN_SEL_PQ_MET) |=> (o_pin_out == $past(pq_met_reg));
    endproperty
    a_pin_pq: assert property (p_pin_pq)
        else $error("pin does not show preamble quality");

    property p_rssi_frozen;
        @(posedge i_clk) disable iff (!i_rst_n)
        (sync_seen_reg && sync_mode[1:0] != 2'h0 && i_rx_active) |=> $stable(rssi_reg);
    endproperty
    a_rssi_frozen: assert property (p_rssi_frozen)
        else $error("rssi changed after sync");

    property p_cs_gate;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_sync_found && cs_qualify) |-> $past(cs_reg);
    endproperty
    a_cs_gate: assert property (p_cs_gate)
        else $error("sync found without carrier sense");

    property p_pq_gate;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_sync_found && pqt_field != 3'h0) |-> $past(pq_met_reg);
    endproperty
    a_pq_gate: assert property (p_pq_gate)
        else $error("sync found without preamble quality");

    property p_fsk_map;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_tx_sym_en && !is_msk) |=> (o_tx_dev_pos == $past(i_tx_sym));
    endproperty
    a_fsk_map: assert property (p_fsk_map)
        else $error("fsk symbol mapping wrong");

    property p_msk_inv;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_tx_sym_en && is_msk) |=> (o_tx_dev_pos != $past(i_tx_sym));
    endproperty
    a_msk_inv: assert property (p_msk_inv)
        else $error("msk bit not inverted");
endmodule

// ---- verif/fe_model.sv ----
// Purpose: front end model feeding demodulated bits and rssi samples
// Assumes: caller steps one strobe at a time on i_clk
// Notes:   data lines are inverted when idle so a stale value never passes
module fe_model (
    input  wire logic       i_clk,
    output logic            o_bit_en,
    output logic            o_bit,
    output logic            o_rssi_en,
    output logic [7:0]      o_rssi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_bit_en = 1'b0;
        o_bit = 1'b0;
        o_rssi_en = 1'b0;
        o_rssi = 8'h00;
    end
    // an idle cycle follows each bit so the match is judged without a strobe
    task automatic send_bit(input logic b);
        @(posedge i_clk) {o_bit_en, o_bit} <= {1'b1, b};
        @(posedge i_clk) {o_bit_en, o_bit} <= {1'b0, ~b};
        @(posedge i_clk);
    endtask
    task automatic send_rssi(input logic [7:0] v);
        @(posedge i_clk) {o_rssi_en, o_rssi} <= {1'b1, v};
        @(posedge i_clk) {o_rssi_en, o_rssi} <= {1'b0, ~v};
    endtask
endmodule

// ---- verif/rx_sync_qualifier_rssi_test.sv ----
// Purpose: self-checking bench for the receive qualifier block
// Assumes: 20 MHz clock; manchester never enabled beside msk
// Notes:   sticky monitors catch one-cycle pulses without racing
`include "rx_qual_consts.svh"
module rx_sync_qualifier_rssi_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_rx_active = 0, i_rx_byte_en = 0;
    logic i_tx_sym_en = 0, i_tx_sym = 0, bit_en, rx_bit, rssi_en, sync_seen, data_seen;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, i_rx_byte = 8'h00, rssi, o_rdata, o_rx_data;
    logic o_rx_data_en, o_sync_found, o_tx_dev_pos, o_gauss_en, o_msk_en, o_rx_dev_use;
    logic o_tx_sync_repeat, o_pin_out;
    logic [31:0] o_dev_hz;
    logic [2:0] o_msk_phase_frac;
    int err_count = 0, compares = 0, cyc = 0;
    rx_sync_qualifier_rssi DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_active(i_rx_active), .i_rx_bit_en(bit_en), .i_rx_bit(rx_bit),
        .i_rx_byte_en(i_rx_byte_en), .i_rx_byte(i_rx_byte), .i_rssi_sample_en(rssi_en),
        .i_rssi_sample(rssi), .i_tx_sym_en(i_tx_sym_en), .i_tx_sym(i_tx_sym),
        .i_tx_sync_phase(1'b0), .o_rx_data_en(o_rx_data_en), .o_rx_data(o_rx_data),
        .o_sync_found(o_sync_found), .o_tx_dev_pos(o_tx_dev_pos), .o_dev_hz(o_dev_hz),
        .o_gauss_en(o_gauss_en), .o_msk_en(o_msk_en), .o_msk_phase_frac(o_msk_phase_frac),
        .o_rx_dev_use(o_rx_dev_use), .o_tx_sync_repeat(o_tx_sync_repeat), .o_pin_out(o_pin_out));
    fe_model fe (.i_clk(i_clk), .o_bit_en(bit_en), .o_bit(rx_bit), .o_rssi_en(rssi_en),
        .o_rssi(rssi));
    always #25 i_clk = ~i_clk;
    // pulses are latched here; rx entry clears them
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (!i_rx_active) {sync_seen, data_seen} <= 2'b00;
        if (o_sync_found) sync_seen <= 1'b1;
        if (o_rx_data_en && o_rx_data === 8'h5A) data_seen <= 1'b1;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic tx_sym(input logic s);
        @(posedge i_clk) {i_tx_sym_en, i_tx_sym} <= {1'b1, s};
        @(posedge i_clk) i_tx_sym_en <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic rx_entry();
        @(posedge i_clk) i_rx_active <= 1'b0;
        repeat (2) @(posedge i_clk) i_rx_active <= 1'b1;
    endtask
    task automatic test_regs();
        logic [7:0] d;
        logic [7:0] exp [9] = '{`RST_SYNC_HIGH, `RST_SYNC_LOW, `RST_PKT_CTRL1, `RST_MODEM_CFG2,
            `RST_DEVIATION, `RST_GAIN_CTRL0, `RST_CS_CTRL, `RST_PIN_CFG, 8'h00};
        for (int i = 0; i < 9; i++) begin
            rd((i == 8) ? 4'hB : 4'(i), d);
            check(d, exp[i], "register reset value");
        end
        $display("test regs done");
    endtask
    task automatic test_modulation();
        wr(`OFS_DEVIATION, 8'h70);
        wr(`OFS_MODEM_CFG2, 8'h12);
        tx_sym(1'b1);
        check(o_dev_hz, 32'h00031975, "deviation value");
        check({o_gauss_en, o_tx_dev_pos}, 2'h3, "gfsk one");
        tx_sym(1'b0);
        check(o_tx_dev_pos, 1'b0, "fsk zero");
        wr(`OFS_DEVIATION, 8'h75);
        wr(`OFS_MODEM_CFG2, 8'h73);
        tx_sym(1'b1);
        check({o_msk_en, o_rx_dev_use, o_tx_dev_pos}, 3'h4, "msk flags");
        check({o_msk_phase_frac, o_tx_sync_repeat}, 4'hB, "msk shape");
        $display("test modulation done");
    endtask
    task automatic test_pq();
        logic [7:0] d;
        wr(`OFS_MODEM_CFG2, 8'h02);
        wr(`OFS_PKT_CTRL1, 8'h20);
        wr(`OFS_PIN_CFG, 8'h08);
        rx_entry();
        for (int i = 0; i < 8; i++) fe.send_bit(i[0]);
        rd(`OFS_STATE_FLAGS, d);
        check({d[5], o_pin_out}, 2'h3, "quality met");
        fe.send_bit(1'b1);
        rd(`OFS_STATE_FLAGS, d);
        check({d[5], o_pin_out}, 2'h0, "quality lost");
        $display("test preamble quality done");
    endtask
    task automatic test_sync();
        logic [7:0] d;
        logic [15:0] w = {`RST_SYNC_HIGH, `RST_SYNC_LOW};
        wr(`OFS_PKT_CTRL1, 8'h04);
        rx_entry();
        repeat (8) fe.send_rssi(8'hE0);
        rd(`OFS_RSSI, d);
        check(d, 8'hE0, "rssi tracks");
        @(posedge i_clk) {i_rx_byte_en, i_rx_byte} <= {1'b1, 8'h5A};
        @(posedge i_clk) i_rx_byte_en <= 1'b0;
        for (int i = 15; i >= 0; i--) fe.send_bit(w[i]);
        repeat (2) @(posedge i_clk);
        check({sync_seen, data_seen}, 2'h2, "sync found, no early data");
        @(posedge i_clk) {i_rx_byte_en, i_rx_byte} <= {1'b1, 8'h5A};
        @(posedge i_clk) i_rx_byte_en <= 1'b0;
        repeat (8) fe.send_rssi(8'h10);
        rd(`OFS_RSSI, d);
        check({d, data_seen}, 9'h1C1, "rssi frozen, data passed");
        rd(`OFS_STATUS_BYTE, d);
        check(d, 8'hE0, "rssi at sync in trailer");
        $display("test sync done");
    endtask
    task automatic test_cs();
        logic [7:0] d;
        wr(`OFS_CS_CTRL, 8'h94);
        wr(`OFS_PIN_CFG, 8'h0E);
        wr(`OFS_MODEM_CFG2, 8'h04);
        rx_entry();
        repeat (8) fe.send_rssi(8'h00);
        @(posedge i_clk);
        rd(`OFS_STATE_FLAGS, d);
        check({d[6], d[0], o_pin_out}, 3'h7, "carrier sense up");
        repeat (8) fe.send_rssi(8'hD0);
        rd(`OFS_STATE_FLAGS, d);
        check({d[6], o_pin_out}, 2'h0, "carrier sense down");
        $display("test carrier sense done");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        test_regs();
        test_modulation();
        test_pq();
        test_sync();
        test_cs();
        close_out();
    end
endmodule
